// [core/irqs_pkg.sv]
// Purpose: shared constants and types of the interrupt and sleep controller
// Assumes: registers are 8 bits wide, program counter is 9 bits wide
// Notes: register offsets are word indices; byte address is four times the index
package irqs_pkg;
  localparam int PC_W = 9;
  localparam int STACK_DEPTH = 3;

  localparam logic [5:0] IDX_MCU_CONTROL = 6'h35;
  localparam logic [5:0] IDX_TIMER_IRQ_FLAGS = 6'h38;
  localparam logic [5:0] IDX_TIMER_IRQ_MASK = 6'h39;
  localparam logic [5:0] IDX_GENERAL_IRQ_MASK = 6'h3B;
  localparam logic [5:0] IDX_GLOBAL_ENABLE = 6'h3C;

  localparam int BIT_OVERFLOW = 1;
  localparam int BIT_SLEEP_ALLOW = 5;
  localparam int BIT_SLEEP_DEPTH = 4;
  localparam int BIT_SENSE_HI = 1;
  localparam int BIT_SENSE_LO = 0;
  localparam int BIT_EXT_MASK = 6;
  localparam int BIT_GLOBAL = 7;

  localparam logic [7:0] RST_MCU_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMER_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_TIMER_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_GENERAL_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_GLOBAL_ENABLE = 8'h00;

  localparam logic [PC_W-1:0] VEC_EXT = 9'h001;
  localparam logic [PC_W-1:0] VEC_OVERFLOW = 9'h002;
  localparam logic [PC_W-1:0] VEC_COMPARATOR = 9'h003;

  localparam logic [2:0] ENTRY_CYCLES = 3'h4;
  localparam logic [2:0] RETURN_CYCLES = 3'h4;

  localparam int CLOCK_KHZ = 40000;
  localparam int RESET_DELAY_TIMEOUT_US = 16000;
  localparam int RESET_DELAY_TIMEOUT_CYCLES = (RESET_DELAY_TIMEOUT_US * CLOCK_KHZ + 999) / 1000;

  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_RSVD = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } irqs_sense_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_ENTRY = 3'b001,
    ST_RETURN = 3'b010,
    ST_IDLE = 3'b011,
    ST_PDOWN = 3'b100
  } irqs_state_t;

  typedef enum logic [1:0] {
    SRC_EXT = 2'b00,
    SRC_OVERFLOW = 2'b01,
    SRC_COMPARATOR = 2'b10
  } irqs_src_t;
endpackage

// [core/irqs_sub_if.sv]
// Purpose: carrier between the controller and its pin and stack helpers
// Assumes: one clock domain
// Notes: ctl is the controller's side
`timescale 1ns/10ps
`default_nettype none
interface irqs_sub_if;
  irqs_pkg::irqs_sense_t sense;
  logic ext_ack;
  logic ext_req;
  logic ext_low;
  logic push;
  logic pop;
  logic [irqs_pkg::PC_W-1:0] push_pc;
  logic [irqs_pkg::PC_W-1:0] top_pc;
  logic [1:0] depth;
  modport ext (input sense, input ext_ack, output ext_req, output ext_low);
  modport stk (input push, input pop, input push_pc, output top_pc, output depth);
  modport ctl (output sense, output ext_ack, output push, output pop, output push_pc,
               input ext_req, input ext_low, input top_pc, input depth);
endinterface
`default_nettype wire

// [core/irqs_ext_sense.sv]
// Purpose: sampling and sense selection for the external interrupt pin
// Assumes: pin is synchronous to clock
// Notes: edge flag is hidden from software
`timescale 1ns/10ps
`default_nettype none
module irqs_ext_sense (
  input wire logic clock,
  input wire logic rst,
  input wire logic ext_irq_pin,
  irqs_sub_if.ext sub
);
  typedef struct packed {
    logic pin_s;
    logic pin_p;
    logic edge_flag;
  } irqs_ext_state_t;

  irqs_ext_state_t s_reg;
  irqs_ext_state_t s_next;
  logic fall;
  logic rise;
  logic edge_hit;

  always_comb
  begin
    s_next = s_reg;
    s_next.pin_s = ext_irq_pin;
    s_next.pin_p = s_reg.pin_s;
    fall = s_reg.pin_p & ~s_reg.pin_s;
    rise = ~s_reg.pin_p & s_reg.pin_s;
    edge_hit = ((sub.sense == irqs_pkg::SENSE_FALL) & fall)
             | ((sub.sense == irqs_pkg::SENSE_RISE) & rise);
    // a new edge beats the acknowledge of the previous one
    if (edge_hit)
    begin
      s_next.edge_flag = 1'b1;
    end
    else if (sub.ext_ack || !sub.sense[1])
    begin
      s_next.edge_flag = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      // samples start at the idle high level so release gives no false edge or low
      s_reg <= '{pin_s: 1'b1, pin_p: 1'b1, edge_flag: 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // level mode has no memory: pending only while low
  assign sub.ext_req = (sub.sense == irqs_pkg::SENSE_LOW) ? ~s_reg.pin_s
                     : (sub.sense[1] & s_reg.edge_flag);
  assign sub.ext_low = ~s_reg.pin_s;
endmodule // irqs_ext_sense
`default_nettype wire

// [core/irqs_ret_stack.sv]
// Purpose: three-entry return-address stack
// Assumes: push and pop never in the same cycle
// Notes: overflow drops the oldest entry, underflow repeats the bottom one
`timescale 1ns/10ps
`default_nettype none
module irqs_ret_stack (
  input wire logic clock,
  input wire logic rst,
  irqs_sub_if.stk sub
);
  typedef struct packed {
    logic [irqs_pkg::STACK_DEPTH-1:0][irqs_pkg::PC_W-1:0] ent;
    logic [1:0] depth;
  } irqs_stk_state_t;

  irqs_stk_state_t s_reg;
  irqs_stk_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (sub.push)
    begin
      s_next.ent = {s_reg.ent[1], s_reg.ent[0], sub.push_pc};
      if (s_reg.depth != 2'(irqs_pkg::STACK_DEPTH))
      begin
        s_next.depth = s_reg.depth + 2'h1;
      end
    end
    else if (sub.pop)
    begin
      s_next.ent = {s_reg.ent[2], s_reg.ent[2], s_reg.ent[1]};
      if (s_reg.depth != 2'h0)
      begin
        s_next.depth = s_reg.depth - 2'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign sub.top_pc = s_reg.ent[0];
  assign sub.depth = s_reg.depth;
endmodule // irqs_ret_stack
`default_nettype wire

// [core/irqs_ctrl.sv]
// Purpose: interrupt and sleep controller with an Avalon-MM register slave
// Assumes: core pulses instr_done at each instruction boundary, with core_pc
//   holding the address of the next instruction
// Notes: every output comes from a flip-flop
`timescale 1ns/10ps
`default_nettype none
module irqs_ctrl #(
  parameter int unsigned TOUT_CYCLES = irqs_pkg::RESET_DELAY_TIMEOUT_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_irq_pin,
  input wire logic overflow_event,
  input wire logic comparator_request,
  output logic comparator_ack,
  input wire logic [irqs_pkg::PC_W-1:0] core_pc,
  input wire logic instr_done,
  input wire logic halt_instr,
  input wire logic reti_instr,
  input wire logic gie_set,
  input wire logic gie_clear,
  output logic core_stall,
  output logic vector_valid,
  output logic [irqs_pkg::PC_W-1:0] vector_pc,
  output logic return_valid,
  output logic [irqs_pkg::PC_W-1:0] return_pc,
  output logic global_enable,
  output logic sleep_idle,
  output logic osc_stop
);
  localparam int TW = $clog2(TOUT_CYCLES + 1);

  typedef struct packed {
    irqs_pkg::irqs_state_t st;
    logic [2:0] cnt;
    irqs_pkg::irqs_src_t src;
    logic skip;
    logic sleep_allow;
    logic sleep_depth_select;
    irqs_pkg::irqs_sense_t sense;
    logic overflow_irq_enable;
    logic overflow_flag;
    logic ext_mask;
    logic gie;
    logic [TW-1:0] low_cnt;
    logic [irqs_pkg::PC_W-1:0] ret_hold;
    logic [7:0] rd;
    logic busy;
    logic cmp_ack;
    logic vec_valid;
    logic [irqs_pkg::PC_W-1:0] vec_pc;
    logic ret_valid;
    logic stall;
    logic idle;
    logic osc_off;
  } irqs_ctrl_state_t;

  irqs_ctrl_state_t s_reg;
  irqs_ctrl_state_t s_next;
  irqs_sub_if sub ();

  logic [5:0] idx;
  logic wr_now;
  logic [7:0] wbyte;
  logic ext_pend;
  logic ovf_pend;
  logic cmp_pend;
  logic any_pend;
  irqs_pkg::irqs_src_t pick;
  logic ack_ext;
  logic ack_ovf;
  logic ovf_w1c;
  logic long_low;

  // unused bits are never stored, so they read zero and ignore writes
  function automatic logic [7:0] reg_read(input logic [5:0] i, input irqs_ctrl_state_t r);
    logic [7:0] v;
    v = 8'h00;
    if (i == irqs_pkg::IDX_MCU_CONTROL)
    begin
      v[irqs_pkg::BIT_SLEEP_ALLOW] = r.sleep_allow;
      v[irqs_pkg::BIT_SLEEP_DEPTH] = r.sleep_depth_select;
      v[irqs_pkg::BIT_SENSE_HI] = r.sense[1];
      v[irqs_pkg::BIT_SENSE_LO] = r.sense[0];
    end
    else if (i == irqs_pkg::IDX_TIMER_IRQ_FLAGS)
    begin
      v[irqs_pkg::BIT_OVERFLOW] = r.overflow_flag;
    end
    else if (i == irqs_pkg::IDX_TIMER_IRQ_MASK)
    begin
      v[irqs_pkg::BIT_OVERFLOW] = r.overflow_irq_enable;
    end
    else if (i == irqs_pkg::IDX_GENERAL_IRQ_MASK)
    begin
      v[irqs_pkg::BIT_EXT_MASK] = r.ext_mask;
    end
    else if (i == irqs_pkg::IDX_GLOBAL_ENABLE)
    begin
      v[irqs_pkg::BIT_GLOBAL] = r.gie;
    end
    return v;
  endfunction

  irqs_ext_sense u_ext (
    .clock(clock),
    .rst(rst),
    .ext_irq_pin(ext_irq_pin),
    .sub(sub)
  );

  irqs_ret_stack u_stack (
    .clock(clock),
    .rst(rst),
    .sub(sub)
  );

  always_comb
  begin
    s_next = s_reg;
    idx = avs_address[7:2];
    wbyte = avs_writedata[7:0];
    // a write lands on the edge where waitrequest is seen low
    wr_now = avs_write & ~s_reg.busy & avs_byteenable[0];
    ext_pend = s_reg.ext_mask & sub.ext_req;
    ovf_pend = s_reg.overflow_irq_enable & s_reg.overflow_flag;
    cmp_pend = comparator_request;
    any_pend = s_reg.gie & (ext_pend | ovf_pend | cmp_pend);
    if (ext_pend)
    begin
      pick = irqs_pkg::SRC_EXT;
    end
    else if (ovf_pend)
    begin
      pick = irqs_pkg::SRC_OVERFLOW;
    end
    else
    begin
      pick = irqs_pkg::SRC_COMPARATOR;
    end
    long_low = (s_reg.low_cnt == TW'(TOUT_CYCLES));
    ack_ext = 1'b0;
    ack_ovf = 1'b0;
    sub.push = 1'b0;
    sub.pop = 1'b0;
    sub.push_pc = core_pc;
    s_next.cmp_ack = 1'b0;
    s_next.vec_valid = 1'b0;
    s_next.ret_valid = 1'b0;

    // bus slave: one wait cycle, then the answer
    if ((avs_read || avs_write) && s_reg.busy)
    begin
      s_next.busy = 1'b0;
    end
    else
    begin
      s_next.busy = 1'b1;
    end
    if (avs_read && s_reg.busy)
    begin
      s_next.rd = reg_read(idx, s_reg);
    end
    ovf_w1c = wr_now && (idx == irqs_pkg::IDX_TIMER_IRQ_FLAGS) && wbyte[irqs_pkg::BIT_OVERFLOW];
    if (wr_now)
    begin
      if (idx == irqs_pkg::IDX_MCU_CONTROL)
      begin
        s_next.sleep_allow = wbyte[irqs_pkg::BIT_SLEEP_ALLOW];
        s_next.sleep_depth_select = wbyte[irqs_pkg::BIT_SLEEP_DEPTH];
        s_next.sense = irqs_pkg::irqs_sense_t'({wbyte[irqs_pkg::BIT_SENSE_HI],
                                               wbyte[irqs_pkg::BIT_SENSE_LO]});
      end
      else if (idx == irqs_pkg::IDX_TIMER_IRQ_MASK)
      begin
        s_next.overflow_irq_enable = wbyte[irqs_pkg::BIT_OVERFLOW];
      end
      else if (idx == irqs_pkg::IDX_GENERAL_IRQ_MASK)
      begin
        s_next.ext_mask = wbyte[irqs_pkg::BIT_EXT_MASK];
      end
      else if (idx == irqs_pkg::IDX_GLOBAL_ENABLE)
      begin
        s_next.gie = wbyte[irqs_pkg::BIT_GLOBAL];
      end
    end
    if (gie_set)
    begin
      s_next.gie = 1'b1;
    end
    else if (gie_clear)
    begin
      s_next.gie = 1'b0;
    end

    // low-level duration for power-down wake; saturates at the limit
    if (!sub.ext_low)
    begin
      s_next.low_cnt = '0;
    end
    else if (!long_low)
    begin
      s_next.low_cnt = s_reg.low_cnt + TW'(1);
    end

    case (s_reg.st)
      irqs_pkg::ST_RUN:
      begin
        if (instr_done)
        begin
          s_next.skip = 1'b0;
        end
        // requests are only taken at an instruction boundary
        if (instr_done && any_pend && !s_reg.skip)
        begin
          s_next.st = irqs_pkg::ST_ENTRY;
          s_next.cnt = 3'h1;
          s_next.src = pick;
          s_next.gie = 1'b0;
          s_next.stall = 1'b1;
          sub.push = 1'b1;
        end
        else if (reti_instr)
        begin
          s_next.st = irqs_pkg::ST_RETURN;
          s_next.cnt = 3'h1;
          s_next.ret_hold = sub.top_pc;
          s_next.stall = 1'b1;
          sub.pop = 1'b1;
        end
        else if (halt_instr && s_reg.sleep_allow)
        begin
          s_next.stall = 1'b1;
          if (s_reg.sleep_depth_select)
          begin
            s_next.st = irqs_pkg::ST_PDOWN;
            s_next.osc_off = 1'b1;
          end
          else
          begin
            s_next.st = irqs_pkg::ST_IDLE;
            s_next.idle = 1'b1;
          end
        end
      end
      irqs_pkg::ST_ENTRY:
      begin
        if (s_reg.cnt == irqs_pkg::ENTRY_CYCLES)
        begin
          s_next.st = irqs_pkg::ST_RUN;
          s_next.stall = 1'b0;
          s_next.vec_valid = 1'b1;
          if (s_reg.src == irqs_pkg::SRC_EXT)
          begin
            s_next.vec_pc = irqs_pkg::VEC_EXT;
            ack_ext = 1'b1;
          end
          else if (s_reg.src == irqs_pkg::SRC_OVERFLOW)
          begin
            s_next.vec_pc = irqs_pkg::VEC_OVERFLOW;
            ack_ovf = 1'b1;
          end
          else
          begin
            s_next.vec_pc = irqs_pkg::VEC_COMPARATOR;
            s_next.cmp_ack = 1'b1;
          end
        end
        else
        begin
          s_next.cnt = s_reg.cnt + 3'h1;
        end
      end
      irqs_pkg::ST_RETURN:
      begin
        if (s_reg.cnt == irqs_pkg::RETURN_CYCLES)
        begin
          s_next.st = irqs_pkg::ST_RUN;
          s_next.stall = 1'b0;
          s_next.gie = 1'b1;
          s_next.ret_valid = 1'b1;
          s_next.skip = 1'b1;
        end
        else
        begin
          s_next.cnt = s_reg.cnt + 3'h1;
        end
      end
      irqs_pkg::ST_IDLE:
      begin
        // no boundary to wait for: the core is parked after the halt
        if (any_pend)
        begin
          s_next.st = irqs_pkg::ST_ENTRY;
          s_next.cnt = 3'h1;
          s_next.src = pick;
          s_next.gie = 1'b0;
          s_next.idle = 1'b0;
          sub.push = 1'b1;
        end
      end
      irqs_pkg::ST_PDOWN:
      begin
        // with the oscillator stopped only a long low level counts
        if (long_low && s_reg.gie && s_reg.ext_mask
            && (s_reg.sense == irqs_pkg::SENSE_LOW))
        begin
          s_next.st = irqs_pkg::ST_ENTRY;
          s_next.cnt = 3'h1;
          s_next.src = irqs_pkg::SRC_EXT;
          s_next.gie = 1'b0;
          s_next.osc_off = 1'b0;
          sub.push = 1'b1;
        end
      end
      default:
      begin
        s_next.st = irqs_pkg::ST_RUN;
        s_next.stall = 1'b0;
      end
    endcase

    // a fresh overflow outlives any clear in the same cycle
    s_next.overflow_flag = (s_reg.overflow_flag & ~(ack_ovf | ovf_w1c)) | overflow_event;
    sub.ext_ack = ack_ext;
    sub.sense = s_reg.sense;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.st <= irqs_pkg::ST_RUN;
      s_reg.busy <= 1'b1;
      s_reg.sense <= irqs_pkg::SENSE_LOW;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata = {24'h000000, s_reg.rd};
  assign avs_waitrequest = s_reg.busy;
  assign comparator_ack = s_reg.cmp_ack;
  assign core_stall = s_reg.stall;
  assign vector_valid = s_reg.vec_valid;
  assign vector_pc = s_reg.vec_pc;
  assign return_valid = s_reg.ret_valid;
  assign return_pc = s_reg.ret_hold;
  assign global_enable = s_reg.gie;
  assign sleep_idle = s_reg.idle;
  assign osc_stop = s_reg.osc_off;
endmodule // irqs_ctrl
`default_nettype wire

// [test/irqs_ctrl_properties.sv]
// Purpose: port-level checks of the interrupt and sleep controller
// Assumes: one clock domain, reset active high
// Notes: bound onto every irqs_ctrl instance
`timescale 1ns/10ps
`default_nettype none
module irqs_ctrl_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic halt_instr,
  input wire logic reti_instr,
  input wire logic core_stall,
  input wire logic vector_valid,
  input wire logic [irqs_pkg::PC_W-1:0] vector_pc,
  input wire logic return_valid,
  input wire logic global_enable,
  input wire logic sleep_idle,
  input wire logic osc_stop,
  input wire logic comparator_ack
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_entry_four_cycles: assert property
    (vector_valid |-> !core_stall && $past(core_stall) && $past(core_stall, 4))
    else $error("entry stall length wrong");
  a_entry_gie_off: assert property
    (vector_valid |-> !global_enable && !$past(global_enable, 3))
    else $error("global enable not cleared on entry");
  a_vector_legal: assert property
    (vector_valid |-> vector_pc inside {9'h001, 9'h002, 9'h003})
    else $error("vector address illegal");
  a_return_timing: assert property
    (return_valid |-> $past(reti_instr, 5) && global_enable && $past(core_stall))
    else $error("return timing or enable wrong");
  a_bus_one_wait: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_single: assert property
    (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_read_upper_zero: assert property
    (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_sleep_cause: assert property
    ($rose(sleep_idle) || $rose(osc_stop) |-> $past(halt_instr))
    else $error("sleep without halt");
  a_sleep_mode_excl: assert property
    (sleep_idle || osc_stop |-> core_stall && !(sleep_idle && osc_stop))
    else $error("sleep mode outputs inconsistent");
  a_idle_wake: assert property
    ($fell(sleep_idle) |-> core_stall ##[1:5] vector_valid)
    else $error("idle wake without prompt vector");
  a_ack_vector: assert property
    (comparator_ack |-> vector_valid && vector_pc == 9'h003)
    else $error("comparator ack without its vector");
  cover property (vector_valid && vector_pc == 9'h001);
  cover property (return_valid);
  cover property ($fell(osc_stop));
  cover property ($fell(sleep_idle));
endmodule // irqs_ctrl_properties
bind irqs_ctrl irqs_ctrl_properties u_props (.clock(clock), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .halt_instr(halt_instr), .reti_instr(reti_instr), .core_stall(core_stall),
  .vector_valid(vector_valid), .vector_pc(vector_pc), .return_valid(return_valid),
  .global_enable(global_enable), .sleep_idle(sleep_idle), .osc_stop(osc_stop),
  .comparator_ack(comparator_ack));
`default_nettype wire

// [test/irqs_core_model.sv]
// Purpose: core and comparator source facing the controller
// Assumes: one instruction boundary every second cycle while running
// Notes: comparator flag held until the controller acknowledges it
`timescale 1ns/10ps
`default_nettype none
module irqs_core_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic core_stall,
  input wire logic comparator_ack,
  input wire logic cmp_set,
  output logic instr_done,
  output logic comparator_request
);
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      instr_done <= 1'b0;
      comparator_request <= 1'b0;
    end
    else
    begin
      // boundaries only while running, so entry never splits an instruction
      instr_done <= !core_stall && !instr_done;
      comparator_request <= cmp_set | (comparator_request & !comparator_ack);
    end
endmodule // irqs_core_model
`default_nettype wire

// [test/tb_irqs_ctrl.sv]
// Purpose: self-checking bench of the interrupt and sleep controller
// Assumes: one wait cycle per bus access, short power-down timeout
// Notes: prints only mismatches and the verdict
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; \
  $display("BAD %s expected %h seen %h", nm, e, s); end end
module tb_irqs_ctrl;
  localparam int TOUT = 20;
  localparam logic [7:0] A_MCU = 8'hD4, A_FLG = 8'hE0, A_MSK = 8'hE4, A_GIM = 8'hEC;
  localparam logic [7:0] A_GIE = 8'hF0;
  localparam logic [7:0] ADDR [6] = '{8'hD4, 8'hE0, 8'hE4, 8'hEC, 8'hF0, 8'hFC};
  localparam logic [7:0] MASK [6] = '{8'h33, 8'h00, 8'h02, 8'h40, 8'h80, 8'h00};
  localparam logic [8:0] PC0 = 9'h1A0;
  logic clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, ext_irq_pin = 1'b1;
  logic overflow_event = 1'b0, halt_instr = 1'b0, reti_instr = 1'b0, gie_set = 1'b0;
  logic cmp_set = 1'b0, gie_clear = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [8:0] core_pc = PC0;
  logic [31:0] avs_readdata;
  logic [8:0] vector_pc, return_pc;
  logic avs_waitrequest, comparator_request, comparator_ack, instr_done, core_stall;
  logic vector_valid, return_valid, global_enable, sleep_idle, osc_stop;
  int n_errors = 0;
  int samples_checked = 0;
  irqs_ctrl #(.TOUT_CYCLES(TOUT)) u_dut (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_irq_pin(ext_irq_pin),
    .overflow_event(overflow_event), .comparator_request(comparator_request),
    .comparator_ack(comparator_ack), .core_pc(core_pc), .instr_done(instr_done),
    .halt_instr(halt_instr), .reti_instr(reti_instr), .gie_set(gie_set), .gie_clear(gie_clear),
    .core_stall(core_stall), .vector_valid(vector_valid), .vector_pc(vector_pc),
    .return_valid(return_valid), .return_pc(return_pc), .global_enable(global_enable),
    .sleep_idle(sleep_idle), .osc_stop(osc_stop));
  irqs_core_model u_core (.clock(clock), .rst(rst), .core_stall(core_stall),
    .comparator_ack(comparator_ack), .cmp_set(cmp_set), .instr_done(instr_done),
    .comparator_request(comparator_request));
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    tally_and_finish();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) hang();
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK("readback", e, q)
  endtask
  task automatic wait_vec(input logic [8:0] e);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (vector_valid !== 1'b1 && n < 200);
    if (vector_valid !== 1'b1) hang();
    `CHK("vector_pc", e, vector_pc)
  endtask
  task automatic ret(input logic [8:0] e);
    int n;
    @(posedge clock);
    reti_instr <= 1'b1;
    @(posedge clock);
    reti_instr <= 1'b0;
    n = 0;
    while (return_valid !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    if (return_valid !== 1'b1) hang();
    `CHK("return_pc", e, return_pc)
  endtask
  task automatic quiet(input int c);
    repeat (c)
    begin
      @(posedge clock);
      `CHK("vector_valid", 1'b0, vector_valid)
    end
  endtask
  task automatic pin_pulse();
    @(posedge clock);
    ext_irq_pin <= 1'b0;
    repeat (2) @(posedge clock);
    ext_irq_pin <= 1'b1;
  endtask
  task automatic pulse_ovf();
    @(posedge clock);
    overflow_event <= 1'b1;
    @(posedge clock);
    overflow_event <= 1'b0;
  endtask
  task automatic pulse_halt();
    @(posedge clock);
    halt_instr <= 1'b1;
    @(posedge clock);
    halt_instr <= 1'b0;
    @(posedge clock);
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(ADDR[i], 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR[i], 8'hFF);
      rd(ADDR[i], MASK[i]);
      wr(ADDR[i], 8'h00);
    end
    avs_byteenable <= 4'h0;
    wr(A_MSK, 8'h02);
    avs_byteenable <= 4'hF;
    rd(A_MSK, 8'h00);
    wr(A_GIE, 8'h80);
    gie_clear <= 1'b1;
    @(posedge clock);
    gie_clear <= 1'b0;
    @(posedge clock);
    `CHK("global_enable", 1'b0, global_enable)
    wr(A_GIE, 8'h80);
    pulse_ovf();
    quiet(8);
    rd(A_FLG, 8'h02);
    wr(A_FLG, 8'h00);
    rd(A_FLG, 8'h02);
    wr(A_FLG, 8'h02);
    rd(A_FLG, 8'h00);
    pulse_ovf();
    wr(A_MSK, 8'h02);
    wait_vec(irqs_pkg::VEC_OVERFLOW);
    `CHK("global_enable", 1'b0, global_enable)
    rd(A_FLG, 8'h00);
    ret(PC0);
    // four nested entries on a held low level; the oldest address is lost
    wr(A_GIM, 8'h40);
    ext_irq_pin <= 1'b0;
    for (int i = 1; i < 4; i++)
    begin
      wait_vec(irqs_pkg::VEC_EXT);
      core_pc <= PC0 + 9'(i);
      gie_set <= 1'b1;
      @(posedge clock);
      gie_set <= 1'b0;
    end
    wait_vec(irqs_pkg::VEC_EXT);
    ext_irq_pin <= 1'b1;
    core_pc <= PC0;
    ret(9'h1A3);
    ret(9'h1A2);
    ret(9'h1A1);
    wr(A_GIE, 8'h00);
    wr(A_MCU, 8'h02);
    pulse_ovf();
    pin_pulse();
    wr(A_GIE, 8'h80);
    wait_vec(irqs_pkg::VEC_EXT);
    ret(PC0);
    quiet(6);
    wait_vec(irqs_pkg::VEC_OVERFLOW);
    ret(PC0);
    for (int c = 1; c < 4; c++)
    begin
      wr(A_MCU, 8'(c));
      pin_pulse();
      if (c == 1)
        quiet(12);
      else
      begin
        wait_vec(irqs_pkg::VEC_EXT);
        ret(PC0);
      end
    end
    // a stale edge is dropped by passing through level sense
    wr(A_GIM, 8'h00);
    pin_pulse();
    wr(A_MCU, 8'h00);
    wr(A_MCU, 8'h03);
    wr(A_GIM, 8'h40);
    quiet(10);
    @(posedge clock);
    cmp_set <= 1'b1;
    @(posedge clock);
    cmp_set <= 1'b0;
    wait_vec(irqs_pkg::VEC_COMPARATOR);
    @(posedge clock);
    `CHK("comparator_request", 1'b0, comparator_request)
    ret(PC0);
    wr(A_MCU, 8'h20);
    pulse_halt();
    `CHK("sleep_idle", 1'b1, sleep_idle)
    pulse_ovf();
    wait_vec(irqs_pkg::VEC_OVERFLOW);
    `CHK("sleep_idle", 1'b0, sleep_idle)
    ret(PC0);
    wr(A_MCU, 8'h00);
    pulse_halt();
    `CHK("sleep_idle", 1'b0, sleep_idle)
    wr(A_MCU, 8'h30);
    pulse_halt();
    `CHK("osc_stop", 1'b1, osc_stop)
    pulse_ovf();
    ext_irq_pin <= 1'b0;
    repeat (TOUT / 2) @(posedge clock);
    ext_irq_pin <= 1'b1;
    quiet(TOUT);
    `CHK("osc_stop", 1'b1, osc_stop)
    ext_irq_pin <= 1'b0;
    wait_vec(irqs_pkg::VEC_EXT);
    ext_irq_pin <= 1'b1;
    ret(PC0);
    wait_vec(irqs_pkg::VEC_OVERFLOW);
    ret(PC0);
    tally_and_finish();
  end
endmodule // tb_irqs_ctrl
`default_nettype wire
